// ===== src/bcd_calendar_clock_bus_port.sv
// Behaviour
// (RQ1) accesses count only with high select high and low select low
// (RQ2) rounding input in seconds 0..29 clears seconds, minutes kept
// (RQ3) rounding input in seconds 30..59 clears seconds and adds one minute
// (RQ4) rounding input is level detected and must stay high 100 us
// (RQ5) selected read strobe drives the addressed nibble onto the data lines
// (RQ6) write strobe stores the data nibble at the four-bit address
// (RQ7) one open-drain active-low output: alarm, 16 Hz or 1 Hz clock
// (RQ8) bank 00 maps addresses 0..C to the time and date counters
// (RQ9) all time and calendar counters are BCD, one digit per nibble
// (RQ10) unused bits ignore writes and read back zero
// (RQ11) address D is mode: timer enable, alarm enable, bank select
// (RQ12) in 12-hour system hours tens bit 1 flags afternoon
// (RQ13) bank 01 holds alarm digits at 2..8, hour system A, leap B
// (RQ14) four data lines and four address lines move one nibble per access
// (RQ15) twenty-six general-purpose nibbles of storage in banks 10 and 11
// (RQ16) counters advance from a 32.768 kHz crystal timebase
// (RQ17) hour system bit 0 picks 12-hour when 0, 24-hour when 1
// (RQ18) leap counter steps with the year; zero means leap year
// (RQ19) writing bit 0 at F clears alarm registers and alarm flip-flop
// (RQ20) bit 1 at F clears prescaler; bits 2,3 low enable 16 Hz, 1 Hz
// (RQ21) seconds carry to minutes, hours, day, month, year with calendar limits
`default_nettype none
module bcd_calendar_clock_bus_port (
	// clock, reset, enable
	input  wire logic       clk_i,
	input  wire logic       srst_i,
	input  wire logic       ce_i,
	// bus port
	input  wire logic       chip_sel_i,
	input  wire logic       chip_sel_n_i,
	input  wire logic       rd_n_i,
	input  wire logic       wr_n_i,
	input  wire logic [3:0] location_select_i,
	input  wire logic [3:0] nibble_bus_i,
	output logic      [3:0] nibble_bus_o,
	output logic            nibble_bus_oe_o,
	// timebase
	input  wire logic       crystal_in_i,
	output logic            crystal_out_o,
	// seconds rounding
	input  wire logic       seconds_round_input_i,
	// open-drain alarm / clock
	output logic            alarm_o,
	output logic            alarm_oe_o
);

	// per-location writable bits; unused bits are forced to zero
	function automatic logic [3:0] bit_mask(input logic alarm_bank, input logic [3:0] a);
		logic [3:0] m;
		m = 4'hf;
		case (a)
			rtc_pkg::ADDR_SEC_U: m = alarm_bank ? 4'h0 : 4'hf;
			rtc_pkg::ADDR_SEC_T: m = alarm_bank ? 4'h0 : 4'h7;
			rtc_pkg::ADDR_MIN_T: m = 4'h7;
			rtc_pkg::ADDR_HR_T:  m = 4'h3;
			rtc_pkg::ADDR_WDAY:  m = 4'h7;
			rtc_pkg::ADDR_DAY_T: m = 4'h3;
			rtc_pkg::ADDR_MON_U: m = alarm_bank ? 4'h0 : 4'hf;
			rtc_pkg::ADDR_MON_T: m = 4'h1;
			rtc_pkg::ADDR_YR_U:  m = alarm_bank ? 4'h3 : 4'hf;
			rtc_pkg::ADDR_YR_T:  m = alarm_bank ? 4'h0 : 4'hf;
			default:             m = 4'hf;
		endcase
		return m;
	endfunction : bit_mask

	function automatic logic [6:0] to_bin(input logic [3:0] t, input logic [3:0] u);
		return 7'(7'(t) * 7'd10 + 7'(u));
	endfunction : to_bin

	function automatic logic [7:0] to_bcd(input logic [6:0] b);
		return {4'(b / 7'd10), 4'(b % 7'd10)};
	endfunction : to_bcd

	// storage
	logic [3:0]              tk_reg [0:rtc_pkg::NUM_CNT-1];
	logic [3:0]              tk_next [0:rtc_pkg::NUM_CNT-1];
	logic [3:0]              alm_reg [0:rtc_pkg::NUM_CNT-1];
	logic [3:0]              ram_reg [0:rtc_pkg::RAM_WORDS-1];
	logic [3:0]              mode_reg;
	logic [1:0]              clk_off_reg;
	logic                    hsel_reg;
	logic [1:0]              leap_reg;
	logic [1:0]              leap_next;
	logic [rtc_pkg::PRE_W-1:0] pre_reg;
	logic                    xtal_prev_reg;
	logic [rtc_pkg::ADJ_CNT_W-1:0] adj_cnt_reg;
	logic                    alarm_ff_reg;
	logic                    match_prev_reg;
	logic                    wr_prev_reg;
	logic [3:0]              wr_addr_reg;
	logic [3:0]              wr_data_reg;

	// decoded strobes and events
	logic                    selected;
	logic                    wr_active;
	logic                    wr_commit;
	logic                    xtal_rise;
	logic                    sec_tick;
	logic                    adj_fire;
	logic                    alarm_match;
	logic [3:0]              rd_data;
	logic [3:0]              wr_masked;
	logic                    wr_cnt;
	logic                    wr_alm;
	logic                    wr_ram;
	logic                    clr_alarm;
	logic                    clr_pre;
	logic [4:0]              ram_idx;
	rtc_pkg::bank_t          bank;

	assign bank      = rtc_pkg::bank_t'(mode_reg[1:0]);
	assign selected  = chip_sel_i & ~chip_sel_n_i; // see (RQ1)
	assign wr_active = selected & ~wr_n_i;
	// data may arrive late in the strobe, so commit on its release
	assign wr_commit = wr_prev_reg & ~wr_active; // see (RQ6)
	assign wr_masked = wr_data_reg & bit_mask(bank == rtc_pkg::BANK_ALARM, wr_addr_reg); // see (RQ10)
	assign wr_cnt    = wr_commit && bank == rtc_pkg::BANK_TIME && wr_addr_reg <= rtc_pkg::ADDR_YR_T;
	assign wr_alm    = wr_commit && bank == rtc_pkg::BANK_ALARM && wr_addr_reg <= rtc_pkg::ADDR_YR_T;
	assign wr_ram    = wr_commit && bank[1] && wr_addr_reg <= rtc_pkg::ADDR_YR_T;
	assign clr_alarm = wr_commit && wr_addr_reg == rtc_pkg::ADDR_CLRCTL && wr_data_reg[rtc_pkg::CLR_ALARM_BIT];
	assign clr_pre   = wr_commit && wr_addr_reg == rtc_pkg::ADDR_CLRCTL && wr_data_reg[rtc_pkg::CLR_PRE_BIT];
	assign ram_idx   = 5'(wr_addr_reg) + (bank[0] ? 5'(rtc_pkg::RAM_PER_BANK) : 5'd0); // see (RQ15)
	assign xtal_rise = crystal_in_i & ~xtal_prev_reg;
	assign sec_tick  = xtal_rise && (&pre_reg) && mode_reg[rtc_pkg::MODE_TIMER_BIT]; // see (RQ16)
	assign adj_fire  = seconds_round_input_i && adj_cnt_reg == rtc_pkg::ADJ_CNT_W'(rtc_pkg::ADJ_MIN_CYC - 1);

	// bus strobe tracking; address and data follow the bus during the strobe
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			wr_prev_reg <= 1'b0;
			wr_addr_reg <= 4'h0;
			wr_data_reg <= 4'h0;
		end else if (ce_i) begin
			wr_prev_reg <= wr_active;
			if (wr_active) begin
				wr_addr_reg <= location_select_i; // see (RQ14)
				wr_data_reg <= nibble_bus_i;
			end
		end
	end

	// crystal edge detect and fifteen-stage prescaler
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			xtal_prev_reg <= 1'b0;
			pre_reg       <= '0;
			crystal_out_o <= 1'b1;
		end else if (ce_i) begin
			xtal_prev_reg <= crystal_in_i;
			crystal_out_o <= ~crystal_in_i;
			if (clr_pre) begin
				pre_reg <= '0; // see (RQ20)
			end else if (xtal_rise) begin
				pre_reg <= pre_reg + 1'b1; // see (RQ16)
			end
		end
	end

	// rounding input: one shot per high level, only after the minimum hold
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			adj_cnt_reg <= '0;
		end else if (ce_i) begin
			if (!seconds_round_input_i) begin
				adj_cnt_reg <= '0;
			end else if (adj_cnt_reg != rtc_pkg::ADJ_CNT_W'(rtc_pkg::ADJ_MIN_CYC)) begin
				adj_cnt_reg <= adj_cnt_reg + 1'b1; // see (RQ4)
			end
		end
	end

	// carry chain worked in binary and written back as bcd digits
	always_comb begin
		logic [6:0] s;
		logic [6:0] m;
		logic [6:0] h;
		logic [6:0] d;
		logic [6:0] mo;
		logic [6:0] y;
		logic [6:0] dmax;
		logic [3:0] wd;
		logic       pm;
		logic       c_min;
		logic       c_hr;
		logic       c_day;
		logic       c_mon;
		logic       c_yr;
		logic [7:0] bcd;
		dmax  = 7'd31;
		bcd   = 8'h00;
		s     = to_bin(tk_reg[rtc_pkg::ADDR_SEC_T], tk_reg[rtc_pkg::ADDR_SEC_U]);
		m     = to_bin(tk_reg[rtc_pkg::ADDR_MIN_T], tk_reg[rtc_pkg::ADDR_MIN_U]);
		d     = to_bin(tk_reg[rtc_pkg::ADDR_DAY_T], tk_reg[rtc_pkg::ADDR_DAY_U]);
		mo    = to_bin(tk_reg[rtc_pkg::ADDR_MON_T], tk_reg[rtc_pkg::ADDR_MON_U]);
		y     = to_bin(tk_reg[rtc_pkg::ADDR_YR_T], tk_reg[rtc_pkg::ADDR_YR_U]);
		wd    = tk_reg[rtc_pkg::ADDR_WDAY];
		pm    = tk_reg[rtc_pkg::ADDR_HR_T][rtc_pkg::HR_PM_BIT];
		h     = hsel_reg ? to_bin({2'b00, tk_reg[rtc_pkg::ADDR_HR_T][1:0]}, tk_reg[rtc_pkg::ADDR_HR_U])
		                 : to_bin({3'b000, tk_reg[rtc_pkg::ADDR_HR_T][0]}, tk_reg[rtc_pkg::ADDR_HR_U]);
		c_min = 1'b0;
		c_hr  = 1'b0;
		c_day = 1'b0;
		c_mon = 1'b0;
		c_yr  = 1'b0;
		for (int i = 0; i < rtc_pkg::NUM_CNT; i++) begin
			tk_next[i] = tk_reg[i];
		end
		leap_next = leap_reg;
		// rounding takes priority over a coincident second tick
		if (adj_fire) begin
			c_min = (s >= 7'd30); // see (RQ3)
			s     = 7'd0; // see (RQ2)
		end else if (sec_tick) begin
			if (s >= 7'd59) begin
				s     = 7'd0;
				c_min = 1'b1; // see (RQ21)
			end else begin
				s = s + 7'd1;
			end
		end
		if (c_min) begin
			if (m >= 7'd59) begin
				m    = 7'd0;
				c_hr = 1'b1;
			end else begin
				m = m + 7'd1;
			end
		end
		if (c_hr) begin
			if (hsel_reg) begin
				if (h >= 7'd23) begin
					h     = 7'd0; // see (RQ17)
					c_day = 1'b1;
				end else begin
					h = h + 7'd1;
				end
			end else if (h == 7'd11) begin
				h     = 7'd12;
				c_day = pm; // 11 pm rolls into a new day
				pm    = ~pm; // see (RQ12)
			end else if (h >= 7'd12) begin
				h = 7'd1;
			end else begin
				h = h + 7'd1;
			end
		end
		// month length, february follows the leap counter
		case (mo)
			7'd2:                      dmax = (leap_reg == 2'b00) ? 7'd29 : 7'd28; // see (RQ18)
			7'd4, 7'd6, 7'd9, 7'd11:   dmax = 7'd30;
			default:                   dmax = 7'd31;
		endcase
		if (c_day) begin
			wd = (wd >= 4'd6) ? 4'd0 : wd + 4'd1;
			if (d >= dmax) begin
				d     = 7'd1;
				c_mon = 1'b1;
			end else begin
				d = d + 7'd1;
			end
		end
		if (c_mon) begin
			if (mo >= 7'd12) begin
				mo   = 7'd1;
				c_yr = 1'b1;
			end else begin
				mo = mo + 7'd1;
			end
		end
		if (c_yr) begin
			y         = (y >= 7'd99) ? 7'd0 : y + 7'd1;
			leap_next = leap_reg + 2'b01; // see (RQ18)
		end
		// write back as bcd digits
		bcd = to_bcd(s);
		tk_next[rtc_pkg::ADDR_SEC_T] = bcd[7:4]; // see (RQ9)
		tk_next[rtc_pkg::ADDR_SEC_U] = bcd[3:0];
		bcd = to_bcd(m);
		tk_next[rtc_pkg::ADDR_MIN_T] = bcd[7:4];
		tk_next[rtc_pkg::ADDR_MIN_U] = bcd[3:0];
		bcd = to_bcd(h);
		tk_next[rtc_pkg::ADDR_HR_T]  = hsel_reg ? {2'b00, bcd[5:4]} : {2'b00, pm, bcd[4]};
		tk_next[rtc_pkg::ADDR_HR_U]  = bcd[3:0];
		tk_next[rtc_pkg::ADDR_WDAY]  = wd;
		bcd = to_bcd(d);
		tk_next[rtc_pkg::ADDR_DAY_T] = bcd[7:4];
		tk_next[rtc_pkg::ADDR_DAY_U] = bcd[3:0];
		bcd = to_bcd(mo);
		tk_next[rtc_pkg::ADDR_MON_T] = bcd[7:4];
		tk_next[rtc_pkg::ADDR_MON_U] = bcd[3:0];
		bcd = to_bcd(y);
		tk_next[rtc_pkg::ADDR_YR_T]  = bcd[7:4];
		tk_next[rtc_pkg::ADDR_YR_U]  = bcd[3:0];
	end

	// per-digit counters and alarm digits; a host write wins over the carry chain
	for (genvar i = 0; i < rtc_pkg::NUM_CNT; i++) begin : g_digit
		localparam logic [3:0] ADDR = 4'(i);
		always_ff @(posedge clk_i) begin
			if (srst_i) begin
				tk_reg[i]  <= (ADDR == rtc_pkg::ADDR_DAY_U) ? rtc_pkg::DAY_U_RST
				            : (ADDR == rtc_pkg::ADDR_MON_U) ? rtc_pkg::MON_U_RST : 4'h0;
				alm_reg[i] <= 4'h0;
			end else if (ce_i) begin
				if (wr_cnt && wr_addr_reg == ADDR) begin
					tk_reg[i] <= wr_masked; // see (RQ8)
				end else begin
					tk_reg[i] <= tk_next[i];
				end
				if (clr_alarm) begin
					alm_reg[i] <= 4'h0; // see (RQ19)
				end else if (wr_alm && wr_addr_reg == ADDR && ADDR >= rtc_pkg::ADDR_MIN_U
				             && ADDR <= rtc_pkg::ADDR_DAY_T) begin
					alm_reg[i] <= wr_masked; // see (RQ13)
				end
			end
		end
	end

	// mode, clock output control, hour system, leap counter
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			mode_reg    <= rtc_pkg::MODE_RST;
			clk_off_reg <= rtc_pkg::CLKOFF_RST;
			hsel_reg    <= rtc_pkg::HSEL_RST;
			leap_reg    <= rtc_pkg::LEAP_RST;
		end else if (ce_i) begin
			if (wr_commit && wr_addr_reg == rtc_pkg::ADDR_MODE) begin
				mode_reg <= wr_data_reg; // see (RQ11)
			end
			if (wr_commit && wr_addr_reg == rtc_pkg::ADDR_CLRCTL) begin
				clk_off_reg <= {wr_data_reg[rtc_pkg::CLK1_OFF_BIT], wr_data_reg[rtc_pkg::CLK16_OFF_BIT]}; // see (RQ20)
			end
			if (wr_alm && wr_addr_reg == rtc_pkg::ADDR_HSEL) begin
				hsel_reg <= wr_masked[0]; // see (RQ17)
			end
			if (wr_alm && wr_addr_reg == rtc_pkg::ADDR_LEAP) begin
				leap_reg <= wr_masked[1:0]; // see (RQ13)
			end else begin
				leap_reg <= leap_next;
			end
		end
	end

	// general-purpose storage
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			for (int i = 0; i < rtc_pkg::RAM_WORDS; i++) begin
				ram_reg[i] <= 4'h0;
			end
		end else if (ce_i && wr_ram) begin
			ram_reg[ram_idx] <= wr_data_reg; // see (RQ15)
		end
	end

	// alarm compares minutes through day digits
	always_comb begin
		alarm_match = 1'b1;
		for (int i = rtc_pkg::ADDR_MIN_U; i <= rtc_pkg::ADDR_DAY_T; i++) begin
			if (alm_reg[i] != tk_reg[i]) begin
				alarm_match = 1'b0;
			end
		end
	end

	// alarm flip-flop; a fresh match wins over a same-cycle clear
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			match_prev_reg <= 1'b0;
			alarm_ff_reg   <= 1'b0;
		end else if (ce_i) begin
			match_prev_reg <= alarm_match;
			if (alarm_match && !match_prev_reg) begin
				alarm_ff_reg <= 1'b1;
			end else if (clr_alarm) begin
				alarm_ff_reg <= 1'b0; // see (RQ19)
			end
		end
	end

	// read mux; E and F are write-only and read zero
	always_comb begin
		logic [4:0] ridx;
		ridx    = 5'(location_select_i) + (bank[0] ? 5'(rtc_pkg::RAM_PER_BANK) : 5'd0);
		rd_data = 4'h0;
		if (location_select_i == rtc_pkg::ADDR_MODE) begin
			rd_data = mode_reg; // see (RQ11)
		end else if (location_select_i <= rtc_pkg::ADDR_YR_T) begin
			case (bank)
				rtc_pkg::BANK_TIME:  rd_data = tk_reg[location_select_i]; // see (RQ8)
				rtc_pkg::BANK_ALARM: begin
					if (location_select_i == rtc_pkg::ADDR_HSEL) begin
						rd_data = {3'b000, hsel_reg};
					end else if (location_select_i == rtc_pkg::ADDR_LEAP) begin
						rd_data = {2'b00, leap_reg};
					end else begin
						rd_data = alm_reg[location_select_i] & bit_mask(1'b1, location_select_i); // see (RQ10)
					end
				end
				default:             rd_data = ram_reg[ridx];
			endcase
		end
	end

	// registered pins; the open-drain output only ever pulls low
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			nibble_bus_o    <= 4'h0;
			nibble_bus_oe_o <= 1'b0;
			alarm_o         <= 1'b0;
			alarm_oe_o      <= 1'b0;
		end else if (ce_i) begin
			nibble_bus_o    <= rd_data;
			nibble_bus_oe_o <= selected & ~rd_n_i; // see (RQ5)
			alarm_o         <= 1'b0;
			alarm_oe_o      <= (mode_reg[rtc_pkg::MODE_ALARM_BIT] & alarm_ff_reg)
			                 | (~clk_off_reg[0] & ~pre_reg[rtc_pkg::TAP_16HZ])
			                 | (~clk_off_reg[1] & ~pre_reg[rtc_pkg::TAP_1HZ]); // see (RQ7)
		end
	end

endmodule : bcd_calendar_clock_bus_port
`default_nettype wire

// ===== src/rtc_pkg.sv
`default_nettype none
package rtc_pkg;
	// clock and timing
	localparam longint CLK_HZ      = 25_000_000;
	localparam longint ADJ_MIN_US  = 100;
	localparam int     ADJ_MIN_CYC = int'((ADJ_MIN_US * CLK_HZ + 64'd999_999) / 64'd1_000_000);
	localparam int     ADJ_CNT_W   = 12;
	localparam int     XTAL_HZ     = 32_768;
	localparam int     PRE_W       = 15;
	localparam int     TAP_16HZ    = 10;
	localparam int     TAP_1HZ     = 14;

	// locations
	localparam logic [3:0] ADDR_SEC_U  = 4'h0;
	localparam logic [3:0] ADDR_SEC_T  = 4'h1;
	localparam logic [3:0] ADDR_MIN_U  = 4'h2;
	localparam logic [3:0] ADDR_MIN_T  = 4'h3;
	localparam logic [3:0] ADDR_HR_U   = 4'h4;
	localparam logic [3:0] ADDR_HR_T   = 4'h5;
	localparam logic [3:0] ADDR_WDAY   = 4'h6;
	localparam logic [3:0] ADDR_DAY_U  = 4'h7;
	localparam logic [3:0] ADDR_DAY_T  = 4'h8;
	localparam logic [3:0] ADDR_MON_U  = 4'h9;
	localparam logic [3:0] ADDR_MON_T  = 4'ha;
	localparam logic [3:0] ADDR_HSEL   = 4'ha;
	localparam logic [3:0] ADDR_YR_U   = 4'hb;
	localparam logic [3:0] ADDR_LEAP   = 4'hb;
	localparam logic [3:0] ADDR_YR_T   = 4'hc;
	localparam logic [3:0] ADDR_MODE   = 4'hd;
	localparam logic [3:0] ADDR_TEST   = 4'he;
	localparam logic [3:0] ADDR_CLRCTL = 4'hf;
	localparam int         NUM_CNT     = 13;

	// mode register fields
	localparam int MODE_TIMER_BIT = 3;
	localparam int MODE_ALARM_BIT = 2;

	// clear and clock output control fields
	localparam int CLR_ALARM_BIT  = 0;
	localparam int CLR_PRE_BIT    = 1;
	localparam int CLK16_OFF_BIT  = 2;
	localparam int CLK1_OFF_BIT   = 3;

	// hours tens fields
	localparam int HR_PM_BIT      = 1;

	// bank codes
	typedef enum logic [1:0] {
		BANK_TIME  = 2'b00,
		BANK_ALARM = 2'b01,
		BANK_RAM0  = 2'b10,
		BANK_RAM1  = 2'b11
	} bank_t;

	// storage
	localparam int RAM_WORDS    = 26;
	localparam int RAM_PER_BANK = 13;

	// reset values
	localparam logic [3:0] MODE_RST   = 4'h0;
	localparam logic [1:0] CLKOFF_RST = 2'b11;
	localparam logic       HSEL_RST   = 1'b1;
	localparam logic [1:0] LEAP_RST   = 2'b00;
	localparam logic [3:0] DAY_U_RST  = 4'h1;
	localparam logic [3:0] MON_U_RST  = 4'h1;
endpackage : rtc_pkg
`default_nettype wire

// ===== test/bcd_calendar_clock_bus_port_sva.sv
`default_nettype none
module rtc_port_sva (
	// clock, reset, enable
	input wire logic       clk_i,
	input wire logic       srst_i,
	input wire logic       ce_i,
	// bus port
	input wire logic       chip_sel_i,
	input wire logic       chip_sel_n_i,
	input wire logic       rd_n_i,
	input wire logic [3:0] location_select_i,
	input wire logic [3:0] nibble_bus_o,
	input wire logic       nibble_bus_oe_o,
	// pins
	input wire logic       crystal_in_i,
	input wire logic       crystal_out_o,
	input wire logic       alarm_o,
	input wire logic       alarm_oe_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic rd_req;

	// selected read request as the device sees it
	assign rd_req = ce_i && chip_sel_i && !chip_sel_n_i && !rd_n_i;

	default clocking @(posedge clk_i); endclocking
	default disable iff (srst_i);

	sequence s_rd_held;
		rd_req ##1 rd_req;
	endsequence

	property p_rd_drive;
		s_rd_held |-> nibble_bus_oe_o;
	endproperty
	a_rd_drive: assert property (p_rd_drive) else $error("data lines not driven during read");
	property p_rd_release;
		ce_i && !rd_req |=> !nibble_bus_oe_o;
	endproperty
	a_rd_release: assert property (p_rd_release) else $error("data lines driven without read");
	property p_desel;
		ce_i && (!chip_sel_i || chip_sel_n_i) |=> !nibble_bus_oe_o;
	endproperty
	a_desel: assert property (p_desel) else $error("deselected device drives bus");
	property p_ef_zero;
		rd_req && location_select_i[3:1] == 3'b111 |=> nibble_bus_o == 4'h0;
	endproperty
	a_ef_zero: assert property (p_ef_zero) else $error("write-only location read nonzero");
	property p_open_drain;
		alarm_o == 1'b0;
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("alarm pin driven high");
	// reset itself must quiet the pins, so no disable here
	property p_reset_quiet;
		disable iff (1'b0) srst_i |=> !nibble_bus_oe_o && !alarm_oe_o && crystal_out_o;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("pins active during reset");
	property p_xtal;
		!$past(srst_i) && $past(ce_i) |-> crystal_out_o == !$past(crystal_in_i);
	endproperty
	a_xtal: assert property (p_xtal) else $error("crystal output not inverse of input");
	// a selected clock phase lasts thousands of cycles, never a glitch
	property p_clk_phase;
		$rose(alarm_oe_o) |=> alarm_oe_o [*7];
	endproperty
	a_clk_phase: assert property (p_clk_phase) else $error("alarm pin pulse too short");
endmodule : rtc_port_sva
`default_nettype wire

// ===== test/bcd_calendar_clock_bus_port_tb.sv
`default_nettype none
module bcd_calendar_clock_bus_port_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, srst, xtal, rnd, cs, cs_n, rd_n, wr_n, oe, xout, alm, alm_oe, ok, ce;
	logic [3:0]  addr, bus_w, dout, d;
	logic [31:0] lfsr_reg;
	logic [23:0] st [6];
	logic [23:0] ex [6];
	int          ln [6];
	int          mismatches, n_compared, cnt;
	localparam logic [63:0] RST0 = 64'h0000_0010_1000_0000;
	localparam logic [63:0] RST1 = 64'h0000_0100_0000_0000;

	bcd_calendar_clock_bus_port i_dut (.clk_i(clk), .srst_i(srst), .ce_i(ce), .chip_sel_i(cs),
		.chip_sel_n_i(cs_n), .rd_n_i(rd_n), .wr_n_i(wr_n), .location_select_i(addr), .nibble_bus_i(bus_w),
		.nibble_bus_o(dout), .nibble_bus_oe_o(oe), .crystal_in_i(xtal), .crystal_out_o(xout),
		.seconds_round_input_i(rnd), .alarm_o(alm), .alarm_oe_o(alm_oe));
	bus_host_model i_host (.clk_i(clk), .chip_sel_o(cs), .chip_sel_n_o(cs_n), .rd_n_o(rd_n), .wr_n_o(wr_n),
		.addr_o(addr), .data_o(bus_w), .dev_data_i(dout), .dev_oe_i(oe));

	function logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr_next
	// readable bits per location, one nibble per address
	function logic [3:0] mask(input logic b, input logic [3:0] a);
		return 4'((b ? 64'h00f0_3103_f73f_7f00 : 64'h00ff_f1f3_f73f_7f7f) >> {a, 2'b00});
	endfunction : mask

	task test_done;
		$display("mismatches=%0d compared=%0d", mismatches, n_compared);
		if (mismatches == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : test_done
	task chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
			mismatches++;
		end
	endtask : chk
	task w(input logic [3:0] a, input logic [3:0] v);
		i_host.wr(a, v, 1'b1, 1'b0);
	endtask : w
	task rchk(input logic [3:0] a, input logic [3:0] e);
		i_host.rd(a, 1'b1, 1'b0, d, ok);
		if (!ok) begin
			mismatches++;
			test_done();
		end
		chk(16'(d), 16'(e));
	endtask : rchk
	// wait bounded for the pin to reach a level
	task wait_pin(input logic lvl);
		for (cnt = 0; cnt < 5000 && alm_oe !== lvl; cnt++) @(negedge clk);
		if (cnt == 5000) begin
			mismatches++;
			test_done();
		end
	endtask : wait_pin

	// 25 MHz clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// fast crystal stand-in: one rising edge every two cycles
	always @(posedge clk) begin
		xtal <= !xtal;
	end

	initial begin
		srst = 1'b1;
		ce = 1'b1;
		xtal = 1'b0;
		rnd = 1'b0;
		lfsr_reg = 32'h9947_04ba;
		st = '{24'h00_0725, 24'h00_0729, 24'h00_0729, 24'h00_0730, 24'h23_5959, 24'h11_5945};
		ex = '{24'h00_0700, 24'h00_0729, 24'h00_0700, 24'h00_0800, 24'h00_0000, 24'h32_0000};
		ln = '{2600, 100, 2600, 2600, 5200, 2600};
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		// reset contents of both banks, mode and write-only places
		for (int b = 0; b < 2; b++) begin
			w(4'hd, 4'(b));
			for (int a = 0; a < 16; a++) rchk(4'(a), a == 13 ? 4'(b) : 4'((b ? RST1 : RST0) >> (4 * a)));
		end
		// random digits, unused bits must drop
		for (int b = 0; b < 2; b++) begin
			w(4'hd, 4'(b));
			for (int a = 0; a < 13; a++) begin
				lfsr_reg = lfsr_next(lfsr_reg);
				w(4'(a), lfsr_reg[3:0] % 4'ha);
				rchk(4'(a), (lfsr_reg[3:0] % 4'ha) & mask(b[0], 4'(a)));
			end
		end
		w(4'hf, 4'hd);
		for (int a = 2; a < 9; a++) rchk(4'(a), 4'h0);
		w(4'ha, 4'h1);
		w(4'hd, 4'h0);
		// writes and reads outside a full select are ignored
		w(4'h0, 4'h3);
		i_host.wr(4'h0, 4'h7, 1'b0, 1'b0);
		i_host.wr(4'h0, 4'h8, 1'b1, 1'b1);
		rchk(4'h0, 4'h3);
		i_host.rd(4'h0, 1'b1, 1'b1, d, ok);
		chk(16'({ok, d}), 16'h000f);
		// a frozen device must not take a whole write strobe
		ce <= 1'b0;
		w(4'h0, 4'h6);
		ce <= 1'b1;
		rchk(4'h0, 4'h3);
		// rounding cases, last one in the 12-hour system
		for (int k = 0; k < 6; k++) begin
			if (k == 5) begin
				w(4'hd, 4'h1);
				w(4'ha, 4'h0);
				w(4'hd, 4'h0);
			end
			w(4'h6, 4'h0);
			w(4'h7, 4'h1);
			w(4'h8, 4'h0);
			for (int a = 0; a < 6; a++) w(4'(a), st[k][4 * a +: 4]);
			@(posedge clk);
			rnd <= 1'b1;
			repeat (ln[k]) @(posedge clk);
			rnd <= 1'b0;
			repeat (4) @(posedge clk);
			for (int a = 0; a < 6; a++) rchk(4'(a), ex[k][4 * a +: 4]);
			if (k == 4) rchk(4'h7, 4'h2);
			if (k == 4) rchk(4'h6, 4'h1);
		end
		// 16 Hz square on the alarm pin, then switched off
		w(4'hf, 4'h8);
		wait_pin(1'b1);
		wait_pin(1'b0);
		wait_pin(1'b1);
		wait_pin(1'b0);
		chk(16'(cnt), 16'd2048);
		w(4'hf, 4'hc);
		cnt = 0;
		repeat (4200) begin
			@(negedge clk);
			cnt += int'(alm_oe !== 1'b0);
		end
		chk(16'(cnt), 16'd0);
		// storage banks 10 and 11 keep separate words at the same address
		lfsr_reg = lfsr_next(lfsr_reg);
		for (int b = 2; b < 4; b++) begin
			w(4'hd, 4'(b));
			w(4'hc, lfsr_reg[3:0] ^ {4{b[0]}});
		end
		for (int b = 2; b < 4; b++) begin
			w(4'hd, 4'(b));
			rchk(4'hc, lfsr_reg[3:0] ^ {4{b[0]}});
		end
		// alarm digits matching the counters pull the pin low until cleared
		w(4'hf, 4'hd);
		w(4'hd, 4'h5);
		w(4'h4, 4'h2);
		w(4'h5, 4'h3);
		repeat (3) @(negedge clk);
		chk(16'(alm_oe), 16'h0000);
		w(4'h7, 4'h1);
		repeat (10) @(negedge clk);
		chk(16'(alm_oe), 16'h0001);
		w(4'hf, 4'hd);
		repeat (3) @(negedge clk);
		chk(16'(alm_oe), 16'h0000);
		test_done();
	end
endmodule : bcd_calendar_clock_bus_port_tb

bind bcd_calendar_clock_bus_port rtc_port_sva i_sva (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i),
	.chip_sel_i(chip_sel_i), .chip_sel_n_i(chip_sel_n_i), .rd_n_i(rd_n_i), .location_select_i(location_select_i),
	.nibble_bus_o(nibble_bus_o), .nibble_bus_oe_o(nibble_bus_oe_o), .crystal_in_i(crystal_in_i),
	.crystal_out_o(crystal_out_o), .alarm_o(alarm_o), .alarm_oe_o(alarm_oe_o));
`default_nettype wire

// ===== test/bus_host_model.sv
`default_nettype none
module bus_host_model (
	// clock
	input wire logic       clk_i,
	// strobes and selects
	output logic           chip_sel_o,
	output logic           chip_sel_n_o,
	output logic           rd_n_o,
	output logic           wr_n_o,
	// address and resolved data wire
	output logic     [3:0] addr_o,
	output logic     [3:0] data_o,
	input wire logic [3:0] dev_data_i,
	input wire logic       dev_oe_i
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       host_drive;
	logic [3:0] wdata;

	// device, then host, else the pull-ups hold the lines high
	assign data_o = dev_oe_i ? dev_data_i : (host_drive ? wdata : 4'hf);

	// idle bus; power-fail side keeps high select up
	initial begin
		chip_sel_o = 1'b1;
		chip_sel_n_o = 1'b1;
		rd_n_o = 1'b1;
		wr_n_o = 1'b1;
		addr_o = 4'h0;
		wdata = 4'h0;
		host_drive = 1'b0;
	end

	// strobe low two cycles, then held address one more edge
	task wr(input logic [3:0] a, input logic [3:0] d, input logic cs, input logic cs_n);
		@(posedge clk_i);
		chip_sel_o <= cs;
		chip_sel_n_o <= cs_n;
		addr_o <= a;
		wdata <= d;
		host_drive <= 1'b1;
		wr_n_o <= 1'b0;
		repeat (2) @(posedge clk_i);
		wr_n_o <= 1'b1;
		@(posedge clk_i);
		chip_sel_o <= 1'b1;
		chip_sel_n_o <= 1'b1;
		host_drive <= 1'b0;
	endtask : wr

	// sample at negedge what the next rising edge sees
	task rd(input logic [3:0] a, input logic cs, input logic cs_n, output logic [3:0] d, output logic ok);
		@(posedge clk_i);
		chip_sel_o <= cs;
		chip_sel_n_o <= cs_n;
		addr_o <= a;
		rd_n_o <= 1'b0;
		ok = 1'b0;
		for (int n = 0; n < 6 && !ok; n++) begin
			@(negedge clk_i);
			ok = (dev_oe_i === 1'b1);
		end
		d = data_o;
		@(posedge clk_i);
		rd_n_o <= 1'b1;
		chip_sel_o <= 1'b1;
		chip_sel_n_o <= 1'b1;
	endtask : rd
endmodule : bus_host_model
`default_nettype wire
